// ### logic/brc_pkg.sv
// Shared constants and types for the bridge configuration header block
package brc_pkg;

  // Register byte offsets
  localparam logic [7:0] BRC_ID_OFFS = 8'h00;
  localparam logic [7:0] BRC_CMD_OFFS = 8'h04;

  // Identification field positions inside the first dword
  localparam int BRC_MAKER_LSB = 0;
  localparam int BRC_PART_LSB = 16;
  localparam int BRC_ID_W = 16;

  // Command field positions
  localparam int BRC_CMD_W = 16;
  localparam int BRC_CMD_IO_EN = 0;
  localparam int BRC_CMD_MEM_EN = 1;
  localparam int BRC_CMD_MASTER_EN = 2;
  localparam int BRC_CMD_PARITY_RSP = 6;
  localparam int BRC_CMD_SYS_ERR_EN = 8;
  localparam int BRC_CMD_INT_DIS = 10;
  localparam int BRC_CMD_RW_N = 6;
  localparam int BRC_CMD_RW_POS [BRC_CMD_RW_N] = '{
    BRC_CMD_IO_EN, BRC_CMD_MEM_EN, BRC_CMD_MASTER_EN,
    BRC_CMD_PARITY_RSP, BRC_CMD_SYS_ERR_EN, BRC_CMD_INT_DIS};
  localparam logic [BRC_CMD_W-1:0] BRC_CMD_RST = 16'h0000;

  // Status half of the command dword
  localparam int BRC_STAT_MDPE = 24;
  localparam logic BRC_STAT_MDPE_RST = 1'b0;

  // Transaction gate lanes
  localparam int BRC_LN_IO = 0;
  localparam int BRC_LN_MEMRD = 1;
  localparam int BRC_LN_MASTER = 2;
  localparam int BRC_LN_SEC = 3;
  localparam int BRC_LN_MWI = 4;
  localparam int BRC_LN_FATAL = 5;
  localparam int BRC_LN_NONFATAL = 6;
  localparam int BRC_LN_INTA = 7;
  localparam int BRC_LN_N = 8;
  localparam logic [BRC_LN_N-1:0] BRC_LN_IDLE = 8'h80;

  // Field access types
  typedef enum logic [2:0] {
    BRC_ACC_RO = 3'h0,
    BRC_ACC_RO_STICKY = 3'h1,
    BRC_ACC_RW = 3'h2,
    BRC_ACC_W1C = 3'h3,
    BRC_ACC_RW_STICKY = 3'h4,
    BRC_ACC_W1C_STICKY = 3'h5
  } brc_acc_t;

endpackage

// ### logic/brc_cfg_if.sv
// Configuration write path from the header decoder to its field cells
`timescale 1ns/1ps
`default_nettype none
interface brc_cfg_if;
  logic wr;
  logic [31:0] wdata;
  logic [3:0] be;
  logic hot_rst;

  modport master (output wr, output wdata, output be, output hot_rst);
  modport field (input wr, input wdata, input be, input hot_rst);
endinterface // brc_cfg_if
`default_nettype wire

// ### logic/brc_field.sv
// One configuration field cell with selectable access type
`timescale 1ns/1ps
`default_nettype none
module brc_field
  import brc_pkg::*;
#(
  parameter int W = 1,
  parameter int LSB = 0,
  parameter brc_acc_t ACC = BRC_ACC_RW,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Write path
  brc_cfg_if.field cfg,
  // Hardware side
  input wire logic [W-1:0] set_i,
  output logic [W-1:0] val_o
);
  typedef struct packed {
    logic [W-1:0] val;
  } brc_fld_st_t;

  localparam bit STICKY = (ACC == BRC_ACC_RO_STICKY) ||
    (ACC == BRC_ACC_RW_STICKY) || (ACC == BRC_ACC_W1C_STICKY);

  brc_fld_st_t st_r;
  brc_fld_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    for (int i = 0; i < W; i++) begin
      unique case (ACC)
        BRC_ACC_RO: st_nxt.val[i] = RST[i];
        BRC_ACC_RO_STICKY: st_nxt.val[i] = st_r.val[i] | set_i[i];
        BRC_ACC_RW, BRC_ACC_RW_STICKY: begin
          if (cfg.wr && cfg.be[(LSB + i) / 8]) begin
            st_nxt.val[i] = cfg.wdata[LSB + i];
          end
        end
        BRC_ACC_W1C, BRC_ACC_W1C_STICKY: begin
          if (cfg.wr && cfg.be[(LSB + i) / 8] && cfg.wdata[LSB + i]) begin
            st_nxt.val[i] = 1'b0; // R1
          end
          if (set_i[i]) begin
            st_nxt.val[i] = 1'b1;
          end
        end
        default: st_nxt.val[i] = RST[i];
      endcase
    end
    // Sticky fields survive a hot reset
    if (cfg.hot_rst && !STICKY) begin
      st_nxt.val = RST; // R2
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r <= '{val: RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign val_o = st_r.val;
endmodule // brc_field
`default_nettype wire

// ### logic/brc_gate.sv
// Registered enable gates for transaction and signalling lanes
`timescale 1ns/1ps
`default_nettype none
module brc_gate #(
  parameter int N = 1,
  parameter logic [N-1:0] IDLE = '0
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Lanes
  input wire logic [N-1:0] req_i,
  input wire logic [N-1:0] en_i,
  output logic [N-1:0] out_o
);
  typedef struct packed {
    logic [N-1:0] q;
  } brc_gate_st_t;

  brc_gate_st_t st_r;
  brc_gate_st_t st_nxt;

  always_comb begin
    st_nxt.q = IDLE ^ (req_i & en_i);
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r <= '{q: IDLE};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign out_o = st_r.q;
endmodule // brc_gate
`default_nettype wire

// ### logic/brc_header.sv
// Type-1 configuration header start: identification and command control
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1: Writing 1 clears a write-one-clear field; writing 0 leaves it.
// R2: Field cells offer six access types; sticky ones survive hot reset.
// R3: Dword 00h bits 15:0 return the fixed maker identifier.
// R4: Dword 00h bits 31:16 return the fixed part identifier.
// R5: Command bit 0 gates response to primary I/O; resets to 0.
// R6: Command bit 1 gates primary memory reads; resets to 0.
// R7: Bit 2 clear blocks primary mastering and secondary responses.
// R8: Bit 2 set lets forwarded secondary traffic master the primary.
// R9: Bit 3 reads 0; no special cycle target response ever.
// R10: Bit 4 reads 0; write-invalidate only issued when forwarding.
// R11: Bits 5, 7, 9 are read-only zero.
// R12: Bit 6 enables parity status setting on poison or parity error.
// R13: Bit 8 with forward mode enables fatal and non-fatal messages.
// R14: Bit 10 set holds the legacy interrupt A output deasserted.
// R15: Status bit 24 is write-one-clear, set on poison when enabled.
// R16: Command bits 15:11 read 0 and ignore writes.
// R17: Writes to identification and hardwired bits are ignored.
module brc_header
  import brc_pkg::*;
#(
  // Arbitrary neutral identification values
  parameter logic [BRC_ID_W-1:0] MAKER_ID = 16'h1A2B,
  parameter logic [BRC_ID_W-1:0] PART_ID = 16'h3C4D
) (
  // Clock and resets
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic hot_rst_i,
  // Configuration access
  input wire logic cfg_req_i,
  input wire logic cfg_wr_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [31:0] cfg_wdata_i,
  input wire logic [3:0] cfg_be_i,
  output logic [31:0] cfg_rdata_o,
  output logic cfg_ack_o,
  // Primary target decode
  input wire logic pri_io_req_i,
  input wire logic pri_mem_rd_req_i,
  output logic pri_io_accept_o,
  output logic pri_mem_rd_accept_o,
  // Forwarding and mastering
  input wire logic sec_fwd_req_i,
  input wire logic sec_txn_req_i,
  input wire logic mwi_fwd_req_i,
  output logic pri_master_grant_o,
  output logic sec_txn_accept_o,
  output logic mwi_issue_o,
  // Parity events on the primary
  input wire logic pri_poison_cpl_i,
  input wire logic pri_poison_wr_i,
  input wire logic pri_parity_err_i,
  // Error messages
  input wire logic fwd_mode_i,
  input wire logic err_fatal_i,
  input wire logic err_nonfatal_i,
  output logic err_fatal_msg_o,
  output logic err_nonfatal_msg_o,
  // Legacy interrupt
  input wire logic intx_req_i,
  output logic legacy_interrupt_a_out_b_o,
  // Status view
  output logic [BRC_CMD_W-1:0] command_control_o,
  output logic mdpe_status_o
);
  typedef struct packed {
    logic [31:0] rdata;
    logic ack;
    logic [BRC_CMD_W-1:0] cmd;
    logic mdpe;
  } brc_hdr_st_t;

  brc_hdr_st_t st_r;
  brc_hdr_st_t st_nxt;

  brc_cfg_if cfg ();

  logic [BRC_CMD_RW_N-1:0] rw_val;
  logic [BRC_CMD_W-1:0] cmd_view;
  logic mdpe_val;
  logic mdpe_set;
  logic [BRC_LN_N-1:0] ln_req;
  logic [BRC_LN_N-1:0] ln_en;
  logic [BRC_LN_N-1:0] ln_out;
  logic hit_id;
  logic hit_cmd;

  assign hit_id = cfg_addr_i == BRC_ID_OFFS;
  assign hit_cmd = cfg_addr_i == BRC_CMD_OFFS;

  // Only the command dword holds writable fields
  assign cfg.wr = cfg_req_i && cfg_wr_i && hit_cmd; // R17
  assign cfg.wdata = cfg_wdata_i;
  assign cfg.be = cfg_be_i;
  assign cfg.hot_rst = hot_rst_i;

  // Writable command bits
  for (genvar k = 0; k < BRC_CMD_RW_N; k++) begin : g_cmd
    brc_field #(
      .W(1),
      .LSB(BRC_CMD_RW_POS[k]),
      .ACC(BRC_ACC_RW),
      .RST(BRC_CMD_RST[BRC_CMD_RW_POS[k]])
    ) u_cmd (
      .ref_clk_i(ref_clk_i),
      .rst_b_i(rst_b_i),
      .cfg(cfg),
      .set_i(1'b0),
      .val_o(rw_val[k])
    );
  end

  // Hardwired and reserved bits stay zero
  always_comb begin
    cmd_view = '0; // R9 R10 R11 R16
    for (int k = 0; k < BRC_CMD_RW_N; k++) begin
      cmd_view[BRC_CMD_RW_POS[k]] = rw_val[k];
    end
  end

  // Master data parity error status
  assign mdpe_set = cmd_view[BRC_CMD_PARITY_RSP] &&
    (pri_poison_cpl_i || pri_poison_wr_i || pri_parity_err_i); // R12 R15

  brc_field #(
    .W(1),
    .LSB(BRC_STAT_MDPE),
    .ACC(BRC_ACC_W1C),
    .RST(BRC_STAT_MDPE_RST)
  ) u_mdpe (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .cfg(cfg),
    .set_i(mdpe_set),
    .val_o(mdpe_val)
  );

  // Lane requests and their enables
  always_comb begin
    ln_req = '0;
    ln_en = '0;
    ln_req[BRC_LN_IO] = pri_io_req_i;
    ln_en[BRC_LN_IO] = cmd_view[BRC_CMD_IO_EN]; // R5
    ln_req[BRC_LN_MEMRD] = pri_mem_rd_req_i;
    ln_en[BRC_LN_MEMRD] = cmd_view[BRC_CMD_MEM_EN]; // R6
    ln_req[BRC_LN_MASTER] = sec_fwd_req_i;
    ln_en[BRC_LN_MASTER] = cmd_view[BRC_CMD_MASTER_EN]; // R7 R8
    ln_req[BRC_LN_SEC] = sec_txn_req_i;
    ln_en[BRC_LN_SEC] = cmd_view[BRC_CMD_MASTER_EN]; // R7
    ln_req[BRC_LN_MWI] = mwi_fwd_req_i;
    ln_en[BRC_LN_MWI] = cmd_view[BRC_CMD_MASTER_EN]; // R10
    ln_req[BRC_LN_FATAL] = err_fatal_i;
    ln_en[BRC_LN_FATAL] = cmd_view[BRC_CMD_SYS_ERR_EN] && fwd_mode_i; // R13
    ln_req[BRC_LN_NONFATAL] = err_nonfatal_i;
    ln_en[BRC_LN_NONFATAL] = cmd_view[BRC_CMD_SYS_ERR_EN] &&
      fwd_mode_i; // R13
    ln_req[BRC_LN_INTA] = intx_req_i;
    ln_en[BRC_LN_INTA] = !cmd_view[BRC_CMD_INT_DIS]; // R14
  end

  brc_gate #(
    .N(BRC_LN_N),
    .IDLE(BRC_LN_IDLE)
  ) u_gate (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .req_i(ln_req),
    .en_i(ln_en),
    .out_o(ln_out)
  );

  // Read decode and answer
  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = cfg_req_i;
    st_nxt.rdata = '0;
    st_nxt.cmd = cmd_view;
    st_nxt.mdpe = mdpe_val;
    if (cfg_req_i && !cfg_wr_i) begin
      if (hit_id) begin
        st_nxt.rdata[BRC_MAKER_LSB +: BRC_ID_W] = MAKER_ID; // R3
        st_nxt.rdata[BRC_PART_LSB +: BRC_ID_W] = PART_ID; // R4
      end else if (hit_cmd) begin
        st_nxt.rdata[BRC_CMD_W-1:0] = cmd_view;
        st_nxt.rdata[BRC_STAT_MDPE] = mdpe_val;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r <= '{rdata: 32'h0000_0000, ack: 1'b0, cmd: BRC_CMD_RST,
                mdpe: BRC_STAT_MDPE_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cfg_rdata_o = st_r.rdata;
  assign cfg_ack_o = st_r.ack;
  assign command_control_o = st_r.cmd;
  assign mdpe_status_o = st_r.mdpe;
  assign pri_io_accept_o = ln_out[BRC_LN_IO];
  assign pri_mem_rd_accept_o = ln_out[BRC_LN_MEMRD];
  assign pri_master_grant_o = ln_out[BRC_LN_MASTER];
  assign sec_txn_accept_o = ln_out[BRC_LN_SEC];
  assign mwi_issue_o = ln_out[BRC_LN_MWI];
  assign err_fatal_msg_o = ln_out[BRC_LN_FATAL];
  assign err_nonfatal_msg_o = ln_out[BRC_LN_NONFATAL];
  assign legacy_interrupt_a_out_b_o = ln_out[BRC_LN_INTA];

  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  w1c_clear_a: assert property ( // R1
    cfg.wr && cfg_be_i[3] && cfg_wdata_i[BRC_STAT_MDPE] && !mdpe_set
    |=> !mdpe_val)
    else $error("status bit not cleared by write of one");

  w1c_hold_a: assert property ( // R1
    mdpe_val && !mdpe_set && !hot_rst_i &&
    !(cfg.wr && cfg_be_i[3] && cfg_wdata_i[BRC_STAT_MDPE]) |=> mdpe_val)
    else $error("status bit lost without a clear");

  id_read_a: assert property ( // R3
    cfg_req_i && !cfg_wr_i && hit_id
    |=> cfg_ack_o && cfg_rdata_o == {PART_ID, MAKER_ID})
    else $error("identification read wrong");

  io_decode_a: assert property ( // R5
    ##1 !$past(cmd_view[BRC_CMD_IO_EN]) |-> !pri_io_accept_o)
    else $error("I/O accepted while decode disabled");

  mem_decode_a: assert property ( // R6
    pri_mem_rd_req_i && cmd_view[BRC_CMD_MEM_EN] |=> pri_mem_rd_accept_o)
    else $error("memory read not accepted while enabled");

  master_off_a: assert property ( // R7
    !cmd_view[BRC_CMD_MASTER_EN] |=> !pri_master_grant_o &&
      !sec_txn_accept_o && !mwi_issue_o)
    else $error("mastering while bus master disabled");

  master_fwd_a: assert property ( // R8
    sec_fwd_req_i && cmd_view[BRC_CMD_MASTER_EN] |=> pri_master_grant_o)
    else $error("forwarded request not mastered");

  hardwired_zero_a: assert property ( // R9 R10 R11
    cfg_ack_o |-> (command_control_o & 16'hFAB8) == 16'h0000)
    else $error("hardwired command bit reads nonzero");

  cmd_readback_a: assert property ( // R16
    cfg_req_i && !cfg_wr_i && hit_cmd
    |=> cfg_rdata_o[15:11] == 5'h00 && cfg_rdata_o[9] == 1'b0 &&
        cfg_rdata_o[7] == 1'b0 && cfg_rdata_o[5:3] == 3'h0)
    else $error("reserved or read-only command bits nonzero");

  parity_set_a: assert property ( // R12
    cmd_view[BRC_CMD_PARITY_RSP] && pri_poison_cpl_i && !hot_rst_i
    |=> mdpe_val)
    else $error("parity status not set");

  parity_off_a: assert property ( // R15
    !mdpe_val && !mdpe_set |=> !mdpe_val)
    else $error("parity status set without enabled event");

  err_msg_a: assert property ( // R13
    err_fatal_i |=> err_fatal_msg_o ==
      $past(cmd_view[BRC_CMD_SYS_ERR_EN] && fwd_mode_i))
    else $error("error message gating wrong");

  intx_mask_a: assert property ( // R14
    cmd_view[BRC_CMD_INT_DIS] |=> legacy_interrupt_a_out_b_o)
    else $error("legacy interrupt asserted while disabled");

  io_accept_a: assert property ( // R5
    pri_io_req_i && cmd_view[BRC_CMD_IO_EN] |=> pri_io_accept_o)
    else $error("I/O not accepted while decode enabled");

  nonfatal_msg_a: assert property ( // R13
    err_nonfatal_i |=> err_nonfatal_msg_o ==
      $past(cmd_view[BRC_CMD_SYS_ERR_EN] && fwd_mode_i))
    else $error("non-fatal message gating wrong");

  intx_pass_a: assert property ( // R14
    intx_req_i && !cmd_view[BRC_CMD_INT_DIS]
    |=> !legacy_interrupt_a_out_b_o)
    else $error("legacy interrupt not asserted while enabled");

  mwi_gate_a: assert property ( // R10
    !mwi_fwd_req_i |=> !mwi_issue_o)
    else $error("write-invalidate issued without forwarding");

  id_write_a: assert property ( // R17
    cfg_req_i && cfg_wr_i && hit_id && !mdpe_set && !hot_rst_i
    |=> $stable(cmd_view) && $stable(mdpe_val))
    else $error("write to identification dword changed state");

  io_enable_cov: cover property (
    cfg.wr && cfg_be_i[0] && cfg_wdata_i[0] ##1 pri_io_req_i ##1
    pri_io_accept_o);
  parity_clear_cov: cover property (mdpe_val ##1 !mdpe_val);
  intx_cov: cover property (!legacy_interrupt_a_out_b_o ##1
    cmd_view[BRC_CMD_INT_DIS] ##1 legacy_interrupt_a_out_b_o);
  err_msg_cov: cover property (err_nonfatal_msg_o);
endmodule // brc_header
`default_nettype wire

// ### verif/brc_host.sv
// Configuration host model driving the header's access port
`timescale 1ns/1ps
`default_nettype none
module brc_host (
  // Clock
  input wire logic ref_clk_i,
  // Access port
  output logic req_o,
  output logic wr_o,
  output logic [7:0] addr_o,
  output logic [31:0] wdata_o,
  output logic [3:0] be_o
);
  initial begin
    req_o = 1'h0;
    wr_o = 1'h0;
    addr_o = 8'h00;
    wdata_o = 32'h0;
    be_o = 4'h0;
  end
  // One access per edge; chained calls run back to back
  task automatic put(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] b);
    @(posedge ref_clk_i);
    req_o <= 1'h1;
    wr_o <= w;
    addr_o <= a;
    wdata_o <= d;
    be_o <= b;
  endtask
  // Released lines show the inverse, never a stale copy
  task automatic idle();
    @(posedge ref_clk_i);
    req_o <= 1'h0;
    wr_o <= ~wr_o;
    addr_o <= ~addr_o;
    wdata_o <= ~wdata_o;
    be_o <= ~be_o;
  endtask
endmodule // brc_host
`default_nettype wire

// ### verif/tb.sv
// Self-checking bench for the configuration header block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e, m) begin \
  comparisons++; \
  if ((a) !== (e)) begin \
    failures++; \
    $display("MISMATCH %0t %s", $time, m); \
  end \
end
module tb;
  import brc_pkg::*;
  localparam logic [15:0] MK = 16'h5A61;  // Arbitrary value
  localparam logic [15:0] PT = 16'h7E02;  // Arbitrary value
  localparam logic [15:0] RW_MASK = 16'h0547;
  logic ref_clk_i = 1'h0;
  logic rst_b_i = 1'h0;
  logic hot_rst_i = 1'h0;
  logic quiet = 1'h1;
  logic [7:0] ln = 8'h00;
  logic [2:0] par = 3'h0;
  logic fwd_mode = 1'h0;
  logic req;
  logic wr;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [3:0] be;
  logic [31:0] rd;
  logic ack;
  logic [7:0] lo;
  logic [15:0] cmdo;
  logic mdpe;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h03C9;
  logic [15:0] cmd_m = 16'h0000;
  logic mdpe_m = 1'h0;
  logic [31:0] exp_rd = 32'h0;
  logic exp_ack = 1'h0;
  logic [7:0] exp_ln = 8'h80;
  logic [15:0] exp_cmd = 16'h0000;
  logic exp_mdpe = 1'h0;
  logic [15:0] wm;
  logic wc;

  always #25 ref_clk_i = ~ref_clk_i;

  brc_host host (
    .ref_clk_i(ref_clk_i),
    .req_o(req),
    .wr_o(wr),
    .addr_o(addr),
    .wdata_o(wdata),
    .be_o(be)
  );

  brc_header #(.MAKER_ID(MK), .PART_ID(PT)) uut (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .hot_rst_i(hot_rst_i),
    .cfg_req_i(req),
    .cfg_wr_i(wr),
    .cfg_addr_i(addr),
    .cfg_wdata_i(wdata),
    .cfg_be_i(be),
    .cfg_rdata_o(rd),
    .cfg_ack_o(ack),
    .pri_io_req_i(ln[0]),
    .pri_mem_rd_req_i(ln[1]),
    .pri_io_accept_o(lo[0]),
    .pri_mem_rd_accept_o(lo[1]),
    .sec_fwd_req_i(ln[2]),
    .sec_txn_req_i(ln[3]),
    .mwi_fwd_req_i(ln[4]),
    .pri_master_grant_o(lo[2]),
    .sec_txn_accept_o(lo[3]),
    .mwi_issue_o(lo[4]),
    .pri_poison_cpl_i(par[0]),
    .pri_poison_wr_i(par[1]),
    .pri_parity_err_i(par[2]),
    .fwd_mode_i(fwd_mode),
    .err_fatal_i(ln[5]),
    .err_nonfatal_i(ln[6]),
    .err_fatal_msg_o(lo[5]),
    .err_nonfatal_msg_o(lo[6]),
    .intx_req_i(ln[7]),
    .legacy_interrupt_a_out_b_o(lo[7]),
    .command_control_o(cmdo),
    .mdpe_status_o(mdpe)
  );

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  assign wm = RW_MASK & {{8{be[1]}}, {8{be[0]}}};
  assign wc = req & wr & (addr == BRC_CMD_OFFS);

  // Reference model and random lane stimulus
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd_m <= 16'h0000;
      mdpe_m <= 1'h0;
      exp_ack <= 1'h0;
      exp_rd <= 32'h0;
      exp_ln <= 8'h80;
      exp_cmd <= 16'h0000;
      exp_mdpe <= 1'h0;
    end else begin
      exp_ln <= {~(ln[7] & ~cmd_m[10]),
                 ln[6:5] & {2{cmd_m[8] & fwd_mode}},
                 ln[4:2] & {3{cmd_m[2]}}, ln[1:0] & cmd_m[1:0]};
      exp_cmd <= cmd_m;
      exp_mdpe <= mdpe_m;
      exp_ack <= req;
      exp_rd <= 32'h0;
      if (req && !wr && addr == BRC_ID_OFFS)
        exp_rd <= {PT, MK};
      if (req && !wr && addr == BRC_CMD_OFFS)
        exp_rd <= {7'h0, mdpe_m, 8'h00, cmd_m};
      if (hot_rst_i)
        cmd_m <= 16'h0000;
      else if (wc)
        cmd_m <= (cmd_m & ~wm) | (wdata[15:0] & wm);
      if (hot_rst_i)
        mdpe_m <= 1'h0;
      else if (cmd_m[6] && |par)
        mdpe_m <= 1'h1;
      else if (wc && be[3] && wdata[24])
        mdpe_m <= 1'h0;
      seed <= xs(seed);
      ln <= seed[7:0];
      par <= quiet ? 3'h0 : seed[10:8];
      fwd_mode <= seed[11];
    end
  end

  always @(negedge ref_clk_i) begin
    `CHK(ack, exp_ack, "ack")
    `CHK(rd, exp_rd, "read data")
    `CHK(lo, exp_ln, "lanes")
    `CHK(cmdo, exp_cmd, "command")
    `CHK(mdpe, exp_mdpe, "parity status")
    cycles++;
    if (cycles == 5000) begin
      failures++;
      finish_test();
    end
  end

  task automatic end_test(input string name);
    $display("Test %s done", name);
  endtask

  task automatic wait_neg(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask

  task automatic finish_test();
    $display("Comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge ref_clk_i);
    rst_b_i <= 1'h1;
    host.put(1'h0, 8'h00, 32'h0, 4'hF);
    host.put(1'h1, 8'h00, 32'hFFFFFFFF, 4'hF);
    host.put(1'h0, 8'h00, 32'h0, 4'hF);
    host.put(1'h0, 8'h08, 32'h0, 4'hF);
    host.idle();
    end_test("ident");
    host.put(1'h1, 8'h04, 32'hFFFFFFFF, 4'hF);
    host.put(1'h0, 8'h04, 32'h0, 4'hF);
    host.idle();
    wait_neg(2);
    `CHK(cmdo, RW_MASK, "hardwired bits")
    end_test("ones");
    @(posedge ref_clk_i);
    quiet <= 1'h0;
    repeat (20) @(posedge ref_clk_i);
    quiet <= 1'h1;
    host.put(1'h1, 8'h04, {7'h0, 1'h0, 8'h00, RW_MASK}, 4'h8);
    host.idle();
    wait_neg(2);
    `CHK(mdpe, 1'h1, "parity set kept")
    host.put(1'h1, 8'h04, 32'h01000000, 4'h8);
    host.idle();
    wait_neg(2);
    `CHK(mdpe, 1'h0, "parity cleared")
    host.put(1'h1, 8'h04, 32'h0, 4'h1);
    host.idle();
    wait_neg(2);
    `CHK(cmdo, 16'h0500, "byte lane")
    end_test("status");
    quiet <= 1'h0;
    repeat (60)
      host.put(seed[12], {5'h00, seed[13], 2'h0}, xs(seed), seed[17:14]);
    host.idle();
    quiet <= 1'h1;
    end_test("random");
    host.put(1'h1, 8'h04, 32'hFFFFFFFF, 4'hF);
    host.idle();
    hot_rst_i <= 1'h1;
    @(posedge ref_clk_i);
    hot_rst_i <= 1'h0;
    wait_neg(2);
    `CHK(cmdo, 16'h0000, "hot reset")
    end_test("hot");
    host.put(1'h1, 8'h04, 32'hFFFFFFFF, 4'hF);
    host.idle();
    rst_b_i <= 1'h0;
    wait_neg(1);
    `CHK(lo, 8'h80, "reset lanes")
    @(posedge ref_clk_i);
    rst_b_i <= 1'h1;
    host.put(1'h0, 8'h04, 32'h0, 4'hF);
    host.idle();
    wait_neg(3);
    end_test("reset");
    finish_test();
  end
endmodule // tb
`default_nettype wire
